// ### pixel_color_matrix_transform.sv
// The implementer's own choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`include "ctm_defs.svh"
// Notes on behaviour
// (RULE_01) Each output channel is a 3x3 matrix times the input RGB plus an offset.
// (RULE_02) There are two instances, correction and luma/chroma, each with its own set.
// (RULE_03) The instance selector picks which instance the controls act on.
// (RULE_04) With correction selected, writing 0 to the apply switch bypasses it, 1 applies it.
// (RULE_05) The illuminant selector picks the active correction set from preset tables.
// (RULE_06) Only in the custom illuminant do value writes define the correction set.
// (RULE_07) Changing the illuminant loads both white-balance ratios, later writes override; selecting the custom illuminant here loads neither ratio.
// (RULE_08) Luma/chroma conversion runs after correction and after gamma.
// (RULE_09) Luma/chroma conversion is active only for a YUV pixel format.
// (RULE_10) With luma/chroma selected, the apply switch is read-only and shows the format.
// (RULE_11) Reading the value returns the coefficient in use at the selected index.
// (RULE_12) The value is carried as a 32-bit float.
// (RULE_13) Saturation adjusts colour only while the vividness switch is 1.
// (RULE_14) Software turns the image processor on before using any of these controls.
// (RULE_15) Index 0..8 names gain row*3+col, 9..11 the three offsets.
// (RULE_16) Each output channel clamps to the pixel range instead of wrapping.
// (RULE_17) Coefficients are signed fixed point and take effect at frame start.
module pixel_color_matrix_transform
    import ctm_pkg::*;
#(
    parameter int PIX_W = `PIX_W
)(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [`ADDR_W-1:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    input wire logic pix_valid_i,
    input wire logic pix_sof_i,
    input wire logic [2:0][PIX_W-1:0] pix_i,
    input wire logic wb_auto_valid_i,
    input wire logic [31:0] wb_auto_red_i,
    input wire logic [31:0] wb_auto_blue_i,
    output logic pix_valid_o,
    output logic pix_sof_o,
    output logic [2:0][PIX_W-1:0] pix_o,
    output logic [31:0] white_balance_red_ratio_o,
    output logic [31:0] white_balance_blue_ratio_o
);
    localparam int CW = `COEF_W;
    localparam int CV = `N_COEF * CW;

    logic image_processor_on_q;
    instance_t transform_instance_select_q;
    logic transform_apply_switch_q;
    logic [`CIDX_W-1:0] coefficient_index_select_q;
    illuminant_t illuminant_table_select_q;
    logic yuv_format_q;
    logic vividness_switch_q;
    logic gamma_on_q;
    coef_t saturation_q;
    logic [CV-1:0] custom_q;
    logic [CV-1:0] act_cc_q;
    logic [CV-1:0] next_cc;
    logic [CV-1:0] yuv_set;
    logic act_apply_q;
    logic act_yuv_q;
    logic act_vivid_q;
    logic act_gamma_q;
    coef_t act_sat_q;
    logic wr_ok;
    logic rd_ok;
    logic frame_start;
    logic [31:0] rd_val;
    coef_t cur_coef;

    // ==========================================================
    // fixed point helpers
    // float to signed Q10, saturating; denormals read as zero
    function automatic coef_t f2x(input logic [31:0] f);
        logic [31:0] mag;
        int sh;
        sh = `FLT_BIAS + `FLT_MANT - `FRAC_W - int'(f[30:23]);
        if (f[30:23] == 8'h00 || sh > 31)
            mag = '0;
        else if (sh <= 0)
            mag = `COEF_MAX;
        else
            mag = {8'h00, 1'b1, f[22:0]} >> sh;
        if (mag > `COEF_MAX)
            mag = `COEF_MAX;
        return f[31] ? -coef_t'(mag) : coef_t'(mag); // RULE_17
    endfunction

    // signed Q10 back to float for readback
    function automatic logic [31:0] x2f(input coef_t x);
        logic [CW-1:0] mag;
        logic [31:0] sh;
        int p;
        mag = x[CW-1] ? CW'(-x) : CW'(x);
        p = 0;
        for (int i = 0; i < CW; i++)
        begin
            if (mag[i])
                p = i;
        end
        sh = 32'(mag) << (`FLT_MANT - p);
        if (mag == '0)
            return '0;
        return {x[CW-1], 8'(p - `FRAC_W + `FLT_BIAS), sh[22:0]}; // RULE_12
    endfunction

    // preset correction tables: diagonal boost, off-diagonal cut, no offset
    function automatic coef_t preset(input illuminant_t il, input int idx);
        coef_t d;
        d = coef_t'({il, 5'h00});
        if (idx >= `N_GAIN)
            return '0;
        if (idx % 4 == 0)
            return `ONE_FX + d;
        return -(d >>> 1);
    endfunction

    // luma/chroma set, Q10 of the usual full-range weights
    function automatic coef_t yuv_coef(input int idx);
        case (idx)
            0: return 20'sd306;
            1: return 20'sd601;
            2: return 20'sd117;
            3: return -20'sd173;
            4: return -20'sd339;
            5: return 20'sd512;
            6: return 20'sd512;
            7: return -20'sd429;
            8: return -20'sd83;
            10, 11: return `CHROMA_MID;
            default: return '0;
        endcase
    endfunction

    // white balance presets per illuminant, red then blue, as floats
    function automatic logic [63:0] wb_preset(input illuminant_t il);
        case (il)
            ILL_TUNGSTEN: return {32'h3f400000, 32'h40000000};
            ILL_WARM_FL: return {32'h3f600000, 32'h3fe00000};
            ILL_COOL_FL: return {32'h3f800000, 32'h3fc00000};
            ILL_DAYLIGHT: return {32'h3fa00000, 32'h3fa00000};
            ILL_CLOUDY: return {32'h3fc00000, 32'h3f800000};
            ILL_SHADE: return {32'h3fe00000, 32'h3f600000};
            default: return {`FLT_ONE, `FLT_ONE};
        endcase
    endfunction

    // ==========================================================
    // register port
    // everything but the processor switch is dead while it is off
    assign wr_ok = wr_i & (image_processor_on_q | addr_i == `OFS_ISP); // RULE_14
    assign rd_ok = rd_i & (image_processor_on_q | addr_i == `OFS_ISP); // RULE_14
    assign frame_start = pix_valid_i & pix_sof_i;

    // control bits
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            image_processor_on_q <= 1'b0;
            transform_instance_select_q <= INST_CORRECTION;
            transform_apply_switch_q <= 1'b1;
            coefficient_index_select_q <= '0;
            illuminant_table_select_q <= ILL_GENERAL;
            yuv_format_q <= 1'b0;
            vividness_switch_q <= 1'b0;
            gamma_on_q <= 1'b0;
            saturation_q <= `ONE_FX;
        end
        else if (wr_ok)
        begin
            case (addr_i)
                `OFS_ISP: image_processor_on_q <= wdata_i[0];
                `OFS_INST: transform_instance_select_q <= instance_t'(wdata_i[0]); // RULE_03
                `OFS_APPLY:
                begin
                    // luma/chroma enable only follows the pixel format
                    if (transform_instance_select_q == INST_CORRECTION)
                        transform_apply_switch_q <= wdata_i[0]; // RULE_04
                end
                `OFS_CIDX: coefficient_index_select_q <= wdata_i[`CIDX_W-1:0]; // RULE_15
                `OFS_ILLUM: illuminant_table_select_q <= illuminant_t'(wdata_i[2:0]); // RULE_05
                `OFS_YUVFMT: yuv_format_q <= wdata_i[0]; // RULE_09
                `OFS_VIVID: vividness_switch_q <= wdata_i[0];
                `OFS_GAMMA: gamma_on_q <= wdata_i[0];
                `OFS_SAT: saturation_q <= wdata_i[31] ? '0 : f2x(wdata_i);
                default: ;
            endcase
        end
    end

    // custom correction set; ignored unless the custom table is chosen
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            custom_q <= '0;
        else if (wr_ok && addr_i == `OFS_CVAL &&
                 transform_instance_select_q == INST_CORRECTION &&
                 illuminant_table_select_q == ILL_CUSTOM &&
                 coefficient_index_select_q < `CIDX_W'(`N_COEF))
            custom_q[coefficient_index_select_q*CW +: CW] <= f2x(wdata_i); // RULE_06
    end

    // white balance ratios: illuminant load, software, then auto loop
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            white_balance_red_ratio_o <= `FLT_ONE;
            white_balance_blue_ratio_o <= `FLT_ONE;
        end
        else if (wr_ok && addr_i == `OFS_ILLUM && wdata_i[2:0] != ILL_CUSTOM)
            {white_balance_red_ratio_o, white_balance_blue_ratio_o} <=
                wb_preset(illuminant_t'(wdata_i[2:0])); // RULE_07
        else if (wr_ok && addr_i == `OFS_WBR)
            white_balance_red_ratio_o <= wdata_i;
        else if (wr_ok && addr_i == `OFS_WBB)
            white_balance_blue_ratio_o <= wdata_i;
        else if (wb_auto_valid_i)
        begin
            white_balance_red_ratio_o <= wb_auto_red_i;
            white_balance_blue_ratio_o <= wb_auto_blue_i;
        end
    end

    // ==========================================================
    // coefficient sets
    for (genvar i = 0; i < `N_COEF; i++)
    begin : g_set
        assign next_cc[i*CW +: CW] = (illuminant_table_select_q == ILL_CUSTOM) ?
            custom_q[i*CW +: CW] : preset(illuminant_table_select_q, i); // RULE_05
        assign yuv_set[i*CW +: CW] = yuv_coef(i); // RULE_02
    end

    // settings in use switch only at frame start; pixels of the last frame sent one or two cycles before it still meet the new gamma or format
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            act_cc_q <= '0;
            act_apply_q <= 1'b0;
            act_yuv_q <= 1'b0;
            act_vivid_q <= 1'b0;
            act_gamma_q <= 1'b0;
            act_sat_q <= `ONE_FX;
        end
        else if (frame_start)
        begin
            act_cc_q <= next_cc; // RULE_17
            act_apply_q <= transform_apply_switch_q;
            act_yuv_q <= yuv_format_q;
            act_vivid_q <= vividness_switch_q;
            act_gamma_q <= gamma_on_q;
            act_sat_q <= saturation_q;
        end
    end

    // ==========================================================
    // readback, one cycle after the strobe
    assign cur_coef = (coefficient_index_select_q >= `CIDX_W'(`N_COEF)) ? '0 :
        (transform_instance_select_q == INST_CORRECTION) ?
        act_cc_q[coefficient_index_select_q*CW +: CW] :
        yuv_set[coefficient_index_select_q*CW +: CW]; // RULE_11

    always_comb
    begin
        case (addr_i)
            `OFS_ISP: rd_val = {31'h0, image_processor_on_q};
            `OFS_INST: rd_val = {31'h0, transform_instance_select_q};
            `OFS_APPLY: rd_val = {31'h0, (transform_instance_select_q == INST_CORRECTION) ?
                transform_apply_switch_q : yuv_format_q}; // RULE_10
            `OFS_CIDX: rd_val = {28'h0, coefficient_index_select_q};
            `OFS_CVAL: rd_val = x2f(cur_coef); // RULE_12
            `OFS_ILLUM: rd_val = {29'h0, illuminant_table_select_q};
            `OFS_YUVFMT: rd_val = {31'h0, yuv_format_q};
            `OFS_VIVID: rd_val = {31'h0, vividness_switch_q};
            `OFS_SAT: rd_val = x2f(saturation_q);
            `OFS_WBR: rd_val = white_balance_red_ratio_o;
            `OFS_WBB: rd_val = white_balance_blue_ratio_o;
            `OFS_GAMMA: rd_val = {31'h0, gamma_on_q};
            default: rd_val = '0;
        endcase
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            rdata_o <= '0;
        else
            rdata_o <= rd_ok ? rd_val : '0;
    end

    // ==========================================================
    // pixel path: correction, saturation, gamma, luma/chroma
    logic s1_valid;
    logic s1_sof;
    logic [2:0][PIX_W-1:0] s1_c;
    logic s2_valid_q;
    logic s2_sof_q;
    logic [2:0][PIX_W-1:0] s2_c_q;
    logic [2:0][PIX_W-1:0] s2_d;
    logic s3_valid_q;
    logic s3_sof_q;
    logic [2:0][PIX_W-1:0] s3_c_q;
    logic [2:0][PIX_W-1:0] s3_d;
    logic [PIX_W+1:0] luma;

    // first pixel of a frame already sees the new set
    matrix_mac #(.PIX_W(PIX_W), .COEF_W(CW)) u_correction (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .valid_i(pix_valid_i),
        .sof_i(pix_sof_i),
        .bypass_i(pix_sof_i ? !transform_apply_switch_q : !act_apply_q), // RULE_04
        .pix_i(pix_i),
        .coef_i(pix_sof_i ? next_cc : act_cc_q),
        .valid_o(s1_valid),
        .sof_o(s1_sof),
        .pix_o(s1_c)
    );

    // cheap luma estimate for saturation: (r + 2g + b) / 4
    assign luma = ({2'b00, s1_c[0]} + {1'b0, s1_c[1], 1'b0} + {2'b00, s1_c[2]}) >> 2;

    for (genvar ch = 0; ch < 3; ch++)
    begin : g_post
        logic signed [CW+PIX_W+2:0] dv;
        logic signed [CW+PIX_W+2:0] sv;
        logic [PIX_W:0] up;
        // push each channel away from luma by the saturation factor
        assign dv = (CW+PIX_W+3)'($signed({1'b0, s1_c[ch]}) - $signed({1'b0, luma[PIX_W-1:0]}))
            * (CW+PIX_W+3)'(act_sat_q);
        // luma term kept signed so the shift of dv stays arithmetic
        assign sv = (dv >>> `FRAC_W) + $signed((CW+PIX_W+3)'({1'b0, luma[PIX_W-1:0]}));
        assign s2_d[ch] = !act_vivid_q ? s1_c[ch] :
            sv[CW+PIX_W+2] ? '0 : (|sv[CW+PIX_W+1:PIX_W]) ? '1 : sv[PIX_W-1:0]; // RULE_13
        // two-segment gamma: steep below the knee, two thirds above
        // product needs the full double width before the shift, or it wraps
        assign up = (PIX_W+1)'(((2*PIX_W+2)'(s2_c_q[ch] - `GAMMA_KNEE)
            * (2*PIX_W+2)'(`GAMMA_SLOPE)) >> 8);
        assign s3_d[ch] = !act_gamma_q ? s2_c_q[ch] :
            (s2_c_q[ch] < `GAMMA_KNEE) ? {s2_c_q[ch][PIX_W-2:0], 1'b0} :
            PIX_W'(`GAMMA_BASE + up);
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            {s2_valid_q, s2_sof_q, s3_valid_q, s3_sof_q} <= '0;
            s2_c_q <= '0;
            s3_c_q <= '0;
        end
        else
        begin
            {s2_valid_q, s2_sof_q, s3_valid_q, s3_sof_q} <=
                {s1_valid, s1_sof, s2_valid_q, s2_sof_q};
            if (s1_valid)
                s2_c_q <= s2_d;
            if (s2_valid_q)
                s3_c_q <= s3_d;
        end
    end

    // conversion last, after gamma, bypassed unless the format is YUV
    matrix_mac #(.PIX_W(PIX_W), .COEF_W(CW)) u_luma_chroma (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .valid_i(s3_valid_q),
        .sof_i(s3_sof_q),
        .bypass_i(!act_yuv_q), // RULE_09
        .pix_i(s3_c_q), // RULE_08
        .coef_i(yuv_set),
        .valid_o(pix_valid_o),
        .sof_o(pix_sof_o),
        .pix_o(pix_o)
    );

    // ==========================================================
    // checks
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    bypass_pass_a: assert property (pix_valid_i && !pix_sof_i && !act_apply_q |=> // RULE_04
        s1_c == $past(pix_i)) else $error("correction bypass altered pixel");
    path_order_a: assert property (pix_valid_i |-> ##4 pix_valid_o) // RULE_08
        else $error("pixel path latency is not four cycles");
    yuv_off_a: assert property (s3_valid_q && !act_yuv_q |=> pix_o == $past(s3_c_q)) // RULE_09
        else $error("conversion active without YUV format");
    sat_off_a: assert property (s1_valid && !act_vivid_q |=> s2_c_q == $past(s1_c)) // RULE_13
        else $error("saturation applied while switched off");
    custom_lock_a: assert property (illuminant_table_select_q != ILL_CUSTOM |=> // RULE_06
        $stable(custom_q)) else $error("custom set changed outside custom table");
    frame_latch_a: assert property (!frame_start |=> $stable(act_cc_q)) // RULE_17
        else $error("coefficients changed mid frame");
    ro_enable_a: assert property (rd_ok && addr_i == `OFS_APPLY && // RULE_10
        transform_instance_select_q == INST_LUMA_CHROMA |=> rdata_o[0] == $past(yuv_format_q))
        else $error("luma/chroma enable does not show format");
    apply_guard_a: assert property (transform_instance_select_q == INST_LUMA_CHROMA |=> // RULE_03
        $stable(transform_apply_switch_q)) else $error("apply switch hit wrong instance");
    wb_load_a: assert property (wr_ok && addr_i == `OFS_ILLUM && // RULE_07
        wdata_i[2:0] != ILL_CUSTOM |=> white_balance_red_ratio_o ==
        (wb_preset(illuminant_t'($past(wdata_i[2:0]))) >> 32)) else $error("wb ratio not loaded");
    access_off_a: assert property (rd_i && !image_processor_on_q && addr_i != `OFS_ISP |=> // RULE_14
        rdata_o == '0) else $error("control readable while processor off");

    custom_frame_c: cover property (frame_start && illuminant_table_select_q == ILL_CUSTOM);
    yuv_frame_c: cover property (pix_sof_o && act_yuv_q);
    vivid_pix_c: cover property (s1_valid && act_vivid_q && act_apply_q);
endmodule

// ### ctm_defs.svh
`ifndef CTM_DEFS_SVH
`define CTM_DEFS_SVH
// pixel and coefficient formats
`define PIX_W 8
`define COEF_W 20
`define FRAC_W 10
`define N_COEF 12
`define N_GAIN 9
`define CIDX_W 4
`define ADDR_W 6
`define ONE_FX 20'sh00400
`define COEF_MAX 32'h0007ffff
`define FLT_BIAS 127
`define FLT_MANT 23
`define FLT_ONE 32'h3f800000
// register offsets
`define OFS_ISP 6'h00
`define OFS_INST 6'h04
`define OFS_APPLY 6'h08
`define OFS_CIDX 6'h0c
`define OFS_CVAL 6'h10
`define OFS_ILLUM 6'h14
`define OFS_YUVFMT 6'h18
`define OFS_VIVID 6'h1c
`define OFS_SAT 6'h20
`define OFS_WBR 6'h24
`define OFS_WBB 6'h28
`define OFS_GAMMA 6'h2c
// gamma curve knee and upper segment
`define GAMMA_KNEE 8'h40
`define GAMMA_BASE 9'h080
`define GAMMA_SLOPE 9'h0ab
// luma/chroma offset for the chroma channels (128.0 in fixed point)
`define CHROMA_MID 20'sh20000
`endif

// ### ctm_pkg.sv
`include "ctm_defs.svh"
package ctm_pkg;
    typedef logic signed [`COEF_W-1:0] coef_t;
    typedef enum logic {INST_CORRECTION = 1'b0, INST_LUMA_CHROMA = 1'b1} instance_t;
    typedef enum logic [2:0] {
        ILL_GENERAL = 3'h0, ILL_TUNGSTEN = 3'h1, ILL_WARM_FL = 3'h2, ILL_COOL_FL = 3'h3,
        ILL_DAYLIGHT = 3'h4, ILL_CLOUDY = 3'h5, ILL_SHADE = 3'h6, ILL_CUSTOM = 3'h7
    } illuminant_t;
endpackage

// ### matrix_mac.sv
`timescale 1ns/1ps
`include "ctm_defs.svh"
module matrix_mac
    import ctm_pkg::*;
#(
    parameter int PIX_W = `PIX_W,
    parameter int COEF_W = `COEF_W
)(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic valid_i,
    input wire logic sof_i,
    input wire logic bypass_i,
    input wire logic [2:0][PIX_W-1:0] pix_i,
    input wire logic [`N_COEF*COEF_W-1:0] coef_i,
    output logic valid_o,
    output logic sof_o,
    output logic [2:0][PIX_W-1:0] pix_o
);
    localparam int ACC_W = COEF_W + PIX_W + 3;
    logic [2:0][PIX_W-1:0] res;

    // ==========================================================
    // three dot products plus offset, clamped to pixel range
    for (genvar ch = 0; ch < 3; ch++)
    begin : g_ch
        logic signed [ACC_W-1:0] acc;
        always_comb
        begin
            acc = ACC_W'($signed(coef_i[(`N_GAIN+ch)*COEF_W +: COEF_W]));
            for (int k = 0; k < 3; k++)
            begin
                acc = acc + ACC_W'($signed(coef_i[(3*ch+k)*COEF_W +: COEF_W])
                    * $signed({1'b0, pix_i[k]}));
            end
        end
        // negative floors at zero, overflow pins at full scale
        assign res[ch] = acc[ACC_W-1] ? '0 :
            (|acc[ACC_W-2:`FRAC_W+PIX_W]) ? '1 : acc[`FRAC_W +: PIX_W]; // RULE_16
    end

    // ==========================================================
    // output register; bypass passes the triplet unchanged
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            valid_o <= 1'b0;
            sof_o <= 1'b0;
            pix_o <= '0;
        end
        else
        begin
            valid_o <= valid_i;
            sof_o <= sof_i & valid_i;
            if (valid_i)
                pix_o <= bypass_i ? pix_i : res; // RULE_01
        end
    end
endmodule

// ### pixel_source.sv
`timescale 1ns/1ps
// ==========================================
// upstream pipeline stage model
// ==========================================
// one triplet per call, no back-pressure; between pixels the data lines show the
// inverse of the last triplet so stale data can never pass for a fresh result
module pixel_source
#(
    parameter int PIX_W = 8
)(
    input wire logic clk_i,
    output logic pix_valid_o = 1'b0,
    output logic pix_sof_o = 1'b0,
    output logic [2:0][PIX_W-1:0] pix_o = '0
);
    // drive for exactly one cycle, launched just after an edge
    task automatic send(input logic sof, input logic [2:0][PIX_W-1:0] p);
        @(posedge clk_i);
        pix_valid_o <= 1'b1;
        pix_sof_o <= sof;
        pix_o <= p;
        @(posedge clk_i);
        pix_valid_o <= 1'b0;
        pix_sof_o <= 1'b0;
        pix_o <= ~p; // released lines do not hold the old value
    endtask
endmodule

// ### pixel_color_matrix_transform_bench.sv
`timescale 1ns/1ps
`include "ctm_defs.svh"
module pixel_color_matrix_transform_bench
    import ctm_pkg::*;
;
    // ==========================================
    // stimulus signals
    // ==========================================
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [`ADDR_W-1:0] addr_i = '0;
    logic [31:0] wdata_i = '0;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic wb_auto_valid = 1'b0;
    logic [31:0] wb_auto_red = '0;
    logic [31:0] wb_auto_blue = '0;
    logic [31:0] rdata_o, wb_red_o, wb_blue_o;
    logic pix_valid_o, pix_sof_o, src_valid, src_sof;
    logic [2:0][7:0] pix_o, src_pix;
    int err_total = 0;
    int num_checks = 0;
    typedef struct {logic [31:0] diag; logic [31:0] off; logic [7:0] r; logic [7:0] gb;} row_t;
    // preset index, diagonal and off-diagonal floats, result for input (200,40,40)
    row_t rows [7] = '{
        '{32'h3f800000, 32'h00000000, 8'd200, 8'd40}, '{32'h3f840000, 32'hbc800000, 8'd205, 8'd37},
        '{32'h3f880000, 32'hbd000000, 8'd210, 8'd35}, '{32'h3f8c0000, 32'hbd400000, 8'd215, 8'd32},
        '{32'h3f900000, 32'hbd800000, 8'd220, 8'd30}, '{32'h3f940000, 32'hbda00000, 8'd225, 8'd27},
        '{32'h3f980000, 32'hbdc00000, 8'd230, 8'd25}};
    localparam logic [23:0] P = {8'd40, 8'd40, 8'd200};

    always #12.5 clk_i = ~clk_i;

    pixel_source src(.clk_i(clk_i), .pix_valid_o(src_valid), .pix_sof_o(src_sof), .pix_o(src_pix));

    pixel_color_matrix_transform dut(.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .pix_valid_i(src_valid),
        .pix_sof_i(src_sof), .pix_i(src_pix), .wb_auto_valid_i(wb_auto_valid),
        .wb_auto_red_i(wb_auto_red), .wb_auto_blue_i(wb_auto_blue), .pix_valid_o(pix_valid_o),
        .pix_sof_o(pix_sof_o), .pix_o(pix_o), .white_balance_red_ratio_o(wb_red_o),
        .white_balance_blue_ratio_o(wb_blue_o));

    // ==========================================
    // shared tasks
    // ==========================================
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // one-cycle strobes; a spare edge between accesses avoids double assignment
    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        @(posedge clk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clk_i);
        wr_i <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [5:0] a, input logic [31:0] exp);
        @(posedge clk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 chk($sformatf("reg %h", a), rdata_o, exp);
    endtask

    // result stands after the fourth edge counting the input edge, not the third
    task automatic px(input logic sof, input logic [23:0] p, input logic [23:0] e);
        src.send(sof, p);
        repeat (2) @(posedge clk_i);
        #1 chk("early valid", {31'h0, pix_valid_o}, 32'h0);
        @(posedge clk_i);
        #1 chk("valid", {31'h0, pix_valid_o}, 32'h1);
        chk("pixel", {8'h00, pix_o}, {8'h00, e});
        chk("sof", {31'h0, pix_sof_o}, {31'h0, sof});
    endtask

    task automatic finish_test;
        if (err_total == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // ==========================================
    // main sequence
    // ==========================================
    initial
    begin
        repeat (10) @(posedge clk_i);
        #1 chk("reset rdata", rdata_o, 32'h0);
        chk("reset valid", {31'h0, pix_valid_o}, 32'h0);
        chk("reset red ratio", wb_red_o, 32'h3f800000);
        @(posedge clk_i);
        rst_i <= 1'b0;
        wr(`OFS_INST, 32'h1);
        rd(`OFS_APPLY, 32'h0);
        wr(`OFS_ISP, 32'h1);
        rd(`OFS_INST, 32'h0);
        rd(6'h30, 32'h0);
        @(posedge clk_i);
        #1 chk("rdata after", rdata_o, 32'h0);
        // every preset table, gains read back by index
        foreach (rows[i])
        begin
            wr(`OFS_ILLUM, i);
            px(1'b1, P, {rows[i].gb, rows[i].gb, rows[i].r});
            wr(`OFS_CIDX, 32'h4);
            rd(`OFS_CVAL, rows[i].diag);
            wr(`OFS_CIDX, 32'h1);
            rd(`OFS_CVAL, rows[i].off);
        end
        wr(`OFS_APPLY, 32'h0);
        px(1'b1, P, P);
        wr(`OFS_APPLY, 32'h1);
        // custom set: gain 4.0 and offset 10.0 only after the next frame start
        wr(`OFS_ILLUM, ILL_CUSTOM);
        wr(`OFS_CIDX, 32'h0);
        wr(`OFS_CVAL, 32'h40800000);
        wr(`OFS_CIDX, 32'h9);
        wr(`OFS_CVAL, 32'h41200000);
        rd(`OFS_CVAL, 32'h0);
        px(1'b0, P, P);
        px(1'b1, P, {8'd0, 8'd0, 8'd255});
        rd(`OFS_CVAL, 32'h41200000);
        // software ratio, then auto pulse, then preset reload
        wr(`OFS_WBR, 32'h40000000);
        chk("red ratio", wb_red_o, 32'h40000000);
        @(posedge clk_i);
        wb_auto_valid <= 1'b1;
        wb_auto_red <= 32'h40400000;
        wb_auto_blue <= 32'h3f000000;
        @(posedge clk_i);
        wb_auto_valid <= 1'b0;
        #1 chk("auto red", wb_red_o, 32'h40400000);
        chk("auto blue", wb_blue_o, 32'h3f000000);
        wr(`OFS_ILLUM, 32'h0);
        chk("preset red", wb_red_o, 32'h3f800000);
        chk("preset blue", wb_blue_o, 32'h3f800000);
        // luma/chroma instance: switch read-only, follows the format
        wr(`OFS_INST, 32'h1);
        wr(`OFS_APPLY, 32'h0);
        rd(`OFS_APPLY, 32'h0);
        wr(`OFS_YUVFMT, 32'h1);
        rd(`OFS_APPLY, 32'h1);
        wr(`OFS_CIDX, 32'h0);
        rd(`OFS_CVAL, 32'h3e990000);
        px(1'b1, {8'd100, 8'd100, 8'd100}, {8'd128, 8'd128, 8'd100});
        // back on correction: the write made under luma/chroma must not have landed
        wr(`OFS_YUVFMT, 32'h0);
        wr(`OFS_INST, 32'h0);
        rd(`OFS_APPLY, 32'h1);
        // saturation 2.0 around luma 80: red clamps high, green and blue floor
        wr(`OFS_VIVID, 32'h1);
        wr(`OFS_SAT, 32'h40000000);
        px(1'b1, P, {8'd0, 8'd0, 8'd255});
        // gamma alone: 40 below the knee doubles, 200 lands on the upper segment
        wr(`OFS_VIVID, 32'h0);
        wr(`OFS_GAMMA, 32'h1);
        px(1'b1, P, {8'd80, 8'd80, 8'd218});
        finish_test();
    end

    // watchdog, well beyond the few hundred cycles the sequence needs
    initial
    begin
        repeat (5000) @(posedge clk_i);
        err_total++;
        finish_test();
    end
endmodule
